//--- src/aecb_pkg.sv
package aecb_pkg;
  // byte addresses in configuration memory
  localparam logic [15:0] ADDR_ENGINE = 16'h2000;
  localparam logic [15:0] ADDR_POL = 16'h2002;
  localparam logic [15:0] ADDR_CONV = 16'h2005;
  localparam logic [15:0] ADDR_BATT = 16'h2020;
  localparam logic [15:0] ADDR_BOOT = 16'h20A7;
  localparam logic [15:0] ADDR_PROG = 16'h20A8;
  localparam logic [15:0] ADDR_SWAP_EN = 16'h20AB;
  localparam logic [15:0] ADDR_SWAP_AB = 16'h20AC;
  localparam logic [15:0] ADDR_SWAP_CD = 16'h20AD;
  // bit positions
  localparam int BIT_CLK_SEL = 3;
  localparam int BIT_RUN_EN = 4;
  localparam int BIT_POL_LO = 4;
  localparam int BIT_CONV_EN = 3;
  localparam int BIT_BATT = 6;
  localparam int BIT_SWAP_EN = 0;
  localparam int BIT_SWAP_LO = 0;
  localparam int BIT_SWAP_HI = 4;
  // reset and wake values
  localparam logic [7:0] RST_BOOT_SIZE = 8'h01;
  localparam logic [7:0] RST_PROG_LOC = 8'h31;
  localparam logic [1:0] RST_POL_MODE = 2'h0;
  // region granule is 1024 bytes
  localparam int REGION_SHIFT = 10;
  localparam int REGION_AW = 8 + REGION_SHIFT;
  // reference polarity modes
  localparam logic [1:0] MODE_TOGGLE_ALT = 2'h0;
  localparam logic [1:0] MODE_POS = 2'h1;
  localparam logic [1:0] MODE_REV = 2'h2;
  localparam logic [1:0] MODE_TOGGLE = 2'h3;

  function automatic logic [REGION_AW-1:0] region_base(input logic [7:0] v);
    return {v, {REGION_SHIFT{1'b0}}};
  endfunction
endpackage

//--- src/aecb_chop_ctrl.sv
`timescale 1ns/1ns
module aecb_chop_ctrl (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // control
  input wire logic [1:0] mode_in,
  input wire logic frame_sync_in,
  input wire logic interval_end_in,
  // results
  output logic ref_swap_out,
  output logic alt_frame_request_out
);
  logic sync_prev_reg;
  logic sync_prev_next;
  logic swap_reg;
  logic swap_next;
  logic alt_reg;
  logic alt_next;
  logic sync_rise;

  assign sync_rise = frame_sync_in & ~sync_prev_reg;

  always_comb begin
    sync_prev_next = frame_sync_in;
    swap_next = swap_reg;
    alt_next = 1'b0;
    if (srst_in) begin
      sync_prev_next = 1'b0;
      swap_next = 1'b0;
    end else if (sync_rise) begin
      case (mode_in)
        aecb_pkg::MODE_POS: swap_next = 1'b0;
        aecb_pkg::MODE_REV: swap_next = 1'b1;
        aecb_pkg::MODE_TOGGLE: swap_next = ~swap_reg;
        aecb_pkg::MODE_TOGGLE_ALT: begin
          if (interval_end_in) begin
            alt_next = 1'b1;
          end else begin
            swap_next = ~swap_reg;
          end
        end
        default: swap_next = swap_reg;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    sync_prev_reg <= sync_prev_next;
    swap_reg <= swap_next;
    alt_reg <= alt_next;
  end

  assign ref_swap_out = swap_reg;
  assign alt_frame_request_out = alt_reg;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  a_swap_held_off_edge: assert property (!sync_rise |=> $stable(ref_swap_out))
    else $error("swap changed without frame sync edge");
  a_fixed_polarity: assert property (sync_rise && mode_in == aecb_pkg::MODE_REV |=> ref_swap_out)
    else $error("reversed mode did not hold swap high");
  a_toggle_no_alt: assert property (sync_rise && mode_in == aecb_pkg::MODE_TOGGLE
    |=> ref_swap_out != $past(ref_swap_out) && !alt_frame_request_out)
    else $error("mode 11 did not toggle or inserted frame");
  a_interval_end_alt: assert property (sync_rise && mode_in == aecb_pkg::MODE_TOGGLE_ALT
    && interval_end_in |=> $stable(ref_swap_out) && alt_frame_request_out)
    else $error("mode 00 interval end mishandled");
  a_pos_polarity: assert property (sync_rise && mode_in == aecb_pkg::MODE_POS |=> !ref_swap_out)
    else $error("positive mode did not hold swap low");
  a_mode00_toggle: assert property (sync_rise && mode_in == aecb_pkg::MODE_TOGGLE_ALT
    && !interval_end_in |=> ref_swap_out != $past(ref_swap_out) && !alt_frame_request_out)
    else $error("mode 00 did not toggle mid interval");
  a_alt_only_end: assert property (!(sync_rise && mode_in == aecb_pkg::MODE_TOGGLE_ALT && interval_end_in)
    |=> !alt_frame_request_out)
    else $error("alternative frame requested outside interval end");
  c_alt_inserted: cover property (alt_frame_request_out);
  c_toggle_twice: cover property (sync_rise ##[1:20] sync_rise);
endmodule // aecb_chop_ctrl

//--- src/aecb_config_bank.sv
`timescale 1ns/1ns
// What this block does
// - Converter enable clear keeps converter, reference and bias off; resets to 0.
// - Battery measure bit applies battery load and connects it to converter at once.
// - Boot region ends at 1024 times boot size field; reset and wake 01.
// - Engine clock select set picks 10 MHz, clear picks 5 MHz.
// - Engine program starts at 1024 times location field; reset and wake 0x31.
// - Reference swap updates only on frame sync rise; 01 positive, 10 reversed.
// - Mode 00 toggles except at interval end, where alternative frame is requested.
// - Mode 11 toggles at every frame sync, never requests alternative frame.
// - Four channel swap bits act only with master enable set; all reset 0.
// - Every bit takes its reset value on reset and wake value on wake, except battery measure, which wake keeps.
module aecb_config_bank (
  // clock and resets
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic wake_in,
  // configuration memory port
  input wire logic [15:0] cfg_addr_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic cfg_rd_in,
  output logic [7:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  // multiplexer timing
  input wire logic multiplexer_frame_sync_in,
  input wire logic accumulation_interval_in,
  // analogue front end controls
  output logic converter_on_out,
  output logic reference_on_out,
  output logic bias_current_on_out,
  output logic battery_load_on_out,
  output logic battery_to_converter_out,
  output logic reference_swap_out,
  output logic alternative_frame_request_out,
  output logic [3:0] current_swap_out,
  // engine and memory controls
  output logic engine_clock_fast_out,
  output logic engine_run_out,
  output logic engine_start_out,
  output logic [aecb_pkg::REGION_AW-1:0] engine_program_base_out,
  output logic [aecb_pkg::REGION_AW-1:0] boot_region_end_out
);
  logic clk_sel_reg;
  logic clk_sel_next;
  logic run_en_reg;
  logic run_en_next;
  logic [1:0] pol_mode_reg;
  logic [1:0] pol_mode_next;
  logic conv_en_reg;
  logic conv_en_next;
  logic batt_meas_reg;
  logic batt_meas_next;
  logic [7:0] boot_size_reg;
  logic [7:0] boot_size_next;
  logic [7:0] prog_loc_reg;
  logic [7:0] prog_loc_next;
  logic swap_master_reg;
  logic swap_master_next;
  logic [3:0] swap_chan_reg;
  logic [3:0] swap_chan_next;
  logic start_reg;
  logic start_next;
  logic [aecb_pkg::REGION_AW-1:0] prog_base_reg;
  logic [aecb_pkg::REGION_AW-1:0] prog_base_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [7:0] rd_byte;

  // configuration bits
  always_comb begin
    clk_sel_next = clk_sel_reg;
    run_en_next = run_en_reg;
    pol_mode_next = pol_mode_reg;
    conv_en_next = conv_en_reg;
    batt_meas_next = batt_meas_reg;
    boot_size_next = boot_size_reg;
    prog_loc_next = prog_loc_reg;
    swap_master_next = swap_master_reg;
    swap_chan_next = swap_chan_reg;
    if (srst_in) begin
      clk_sel_next = 1'b0;
      run_en_next = 1'b0;
      pol_mode_next = aecb_pkg::RST_POL_MODE;
      conv_en_next = 1'b0;
      batt_meas_next = 1'b0;
      boot_size_next = aecb_pkg::RST_BOOT_SIZE;
      prog_loc_next = aecb_pkg::RST_PROG_LOC;
      swap_master_next = 1'b0;
      swap_chan_next = 4'h0;
    end else if (wake_in) begin
      // battery measure wake value is undefined: kept
      clk_sel_next = 1'b0;
      run_en_next = 1'b0;
      pol_mode_next = aecb_pkg::RST_POL_MODE;
      conv_en_next = 1'b0;
      boot_size_next = aecb_pkg::RST_BOOT_SIZE;
      prog_loc_next = aecb_pkg::RST_PROG_LOC;
      swap_master_next = 1'b0;
      swap_chan_next = 4'h0;
    end else if (cfg_wr_in) begin
      case (cfg_addr_in)
        aecb_pkg::ADDR_ENGINE: begin
          clk_sel_next = cfg_wdata_in[aecb_pkg::BIT_CLK_SEL];
          run_en_next = cfg_wdata_in[aecb_pkg::BIT_RUN_EN];
        end
        aecb_pkg::ADDR_POL: begin
          pol_mode_next = cfg_wdata_in[aecb_pkg::BIT_POL_LO +: 2];
        end
        aecb_pkg::ADDR_CONV: begin
          conv_en_next = cfg_wdata_in[aecb_pkg::BIT_CONV_EN];
        end
        aecb_pkg::ADDR_BATT: begin
          batt_meas_next = cfg_wdata_in[aecb_pkg::BIT_BATT];
        end
        aecb_pkg::ADDR_BOOT: begin
          boot_size_next = cfg_wdata_in;
        end
        aecb_pkg::ADDR_PROG: begin
          prog_loc_next = cfg_wdata_in;
        end
        aecb_pkg::ADDR_SWAP_EN: begin
          swap_master_next = cfg_wdata_in[aecb_pkg::BIT_SWAP_EN];
        end
        aecb_pkg::ADDR_SWAP_AB: begin
          swap_chan_next[0] = cfg_wdata_in[aecb_pkg::BIT_SWAP_LO];
          swap_chan_next[1] = cfg_wdata_in[aecb_pkg::BIT_SWAP_HI];
        end
        aecb_pkg::ADDR_SWAP_CD: begin
          swap_chan_next[2] = cfg_wdata_in[aecb_pkg::BIT_SWAP_LO];
          swap_chan_next[3] = cfg_wdata_in[aecb_pkg::BIT_SWAP_HI];
        end
        default: begin
          clk_sel_next = clk_sel_reg;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    clk_sel_reg <= clk_sel_next;
    run_en_reg <= run_en_next;
    pol_mode_reg <= pol_mode_next;
    conv_en_reg <= conv_en_next;
    batt_meas_reg <= batt_meas_next;
    boot_size_reg <= boot_size_next;
    prog_loc_reg <= prog_loc_next;
    swap_master_reg <= swap_master_next;
    swap_chan_reg <= swap_chan_next;
  end

  // engine start: program base latched as the engine comes up
  always_comb begin
    start_next = run_en_next & ~run_en_reg;
    prog_base_next = prog_base_reg;
    if (srst_in) begin
      prog_base_next = aecb_pkg::region_base(aecb_pkg::RST_PROG_LOC);
    end else if (start_next) begin
      prog_base_next = aecb_pkg::region_base(prog_loc_next);
    end else if (!run_en_next) begin
      prog_base_next = aecb_pkg::region_base(prog_loc_next);
    end
  end

  always_ff @(posedge mclk_in) begin
    start_reg <= start_next;
    prog_base_reg <= prog_base_next;
  end

  // readback, unmapped bytes read zero
  always_comb begin
    rd_byte = 8'h00;
    case (cfg_addr_in)
      aecb_pkg::ADDR_ENGINE: begin
        rd_byte[aecb_pkg::BIT_CLK_SEL] = clk_sel_reg;
        rd_byte[aecb_pkg::BIT_RUN_EN] = run_en_reg;
      end
      aecb_pkg::ADDR_POL: rd_byte[aecb_pkg::BIT_POL_LO +: 2] = pol_mode_reg;
      aecb_pkg::ADDR_CONV: rd_byte[aecb_pkg::BIT_CONV_EN] = conv_en_reg;
      aecb_pkg::ADDR_BATT: rd_byte[aecb_pkg::BIT_BATT] = batt_meas_reg;
      aecb_pkg::ADDR_BOOT: rd_byte = boot_size_reg;
      aecb_pkg::ADDR_PROG: rd_byte = prog_loc_reg;
      aecb_pkg::ADDR_SWAP_EN: rd_byte[aecb_pkg::BIT_SWAP_EN] = swap_master_reg;
      aecb_pkg::ADDR_SWAP_AB: begin
        rd_byte[aecb_pkg::BIT_SWAP_LO] = swap_chan_reg[0];
        rd_byte[aecb_pkg::BIT_SWAP_HI] = swap_chan_reg[1];
      end
      aecb_pkg::ADDR_SWAP_CD: begin
        rd_byte[aecb_pkg::BIT_SWAP_LO] = swap_chan_reg[2];
        rd_byte[aecb_pkg::BIT_SWAP_HI] = swap_chan_reg[3];
      end
      default: rd_byte = 8'h00;
    endcase
    rvalid_next = cfg_rd_in & ~srst_in;
    rdata_next = rdata_reg;
    if (srst_in) begin
      rdata_next = 8'h00;
    end else if (cfg_rd_in) begin
      rdata_next = rd_byte;
    end
  end

  always_ff @(posedge mclk_in) begin
    rdata_reg <= rdata_next;
    rvalid_reg <= rvalid_next;
  end

  aecb_chop_ctrl aecb_chop_ctrl_i (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .mode_in(pol_mode_reg),
    .frame_sync_in(multiplexer_frame_sync_in),
    .interval_end_in(accumulation_interval_in),
    .ref_swap_out(reference_swap_out),
    .alt_frame_request_out(alternative_frame_request_out)
  );

  assign cfg_rdata_out = rdata_reg;
  assign cfg_rvalid_out = rvalid_reg;
  assign converter_on_out = conv_en_reg;
  assign reference_on_out = conv_en_reg;
  assign bias_current_on_out = conv_en_reg;
  assign battery_load_on_out = batt_meas_reg;
  assign battery_to_converter_out = batt_meas_reg;
  assign current_swap_out = swap_chan_reg & {4{swap_master_reg}};
  assign engine_clock_fast_out = clk_sel_reg;
  assign engine_run_out = run_en_reg;
  assign engine_start_out = start_reg;
  assign engine_program_base_out = prog_base_reg;
  assign boot_region_end_out = aecb_pkg::region_base(boot_size_reg);

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  // writes refused during wake are left out of the antecedents
  logic wr_conv;
  logic wr_engine;
  logic wr_batt;
  logic wr_boot;
  logic wr_swap_en;
  assign wr_conv = cfg_wr_in && !wake_in && cfg_addr_in == aecb_pkg::ADDR_CONV;
  assign wr_engine = cfg_wr_in && !wake_in && cfg_addr_in == aecb_pkg::ADDR_ENGINE;
  assign wr_batt = cfg_wr_in && !wake_in && cfg_addr_in == aecb_pkg::ADDR_BATT;
  assign wr_boot = cfg_wr_in && !wake_in && cfg_addr_in == aecb_pkg::ADDR_BOOT;
  assign wr_swap_en = cfg_wr_in && !wake_in && cfg_addr_in == aecb_pkg::ADDR_SWAP_EN;

  a_converter_off: assert property (wr_conv && !cfg_wdata_in[aecb_pkg::BIT_CONV_EN]
    |=> !converter_on_out && !reference_on_out && !bias_current_on_out)
    else $error("converter not off after enable cleared");
  a_battery_at_once: assert property (cfg_wr_in && !wake_in && cfg_addr_in == aecb_pkg::ADDR_BATT
    && cfg_wdata_in[aecb_pkg::BIT_BATT] |=> battery_load_on_out && battery_to_converter_out)
    else $error("battery load not applied after write");
  a_boot_end_addr: assert property (cfg_wr_in && !wake_in && cfg_addr_in == aecb_pkg::ADDR_BOOT
    |=> boot_region_end_out == {$past(cfg_wdata_in), 10'h000})
    else $error("boot region end wrong");
  a_engine_clock: assert property (wr_engine
    |=> engine_clock_fast_out == $past(cfg_wdata_in[aecb_pkg::BIT_CLK_SEL]))
    else $error("engine clock select not applied");
  a_program_base: assert property (wr_engine && cfg_wdata_in[aecb_pkg::BIT_RUN_EN] && !engine_run_out
    |=> engine_start_out && engine_program_base_out == {prog_loc_reg, 10'h000})
    else $error("engine start base wrong");
  a_swap_gated: assert property (current_swap_out != 4'h0 |-> swap_master_reg)
    else $error("channel swap without master enable");
  a_wake_values: assert property (wake_in |=> !engine_run_out && !converter_on_out
    && boot_region_end_out == aecb_pkg::region_base(aecb_pkg::RST_BOOT_SIZE)
    && engine_program_base_out == aecb_pkg::region_base(aecb_pkg::RST_PROG_LOC)
    && current_swap_out == 4'h0)
    else $error("wake values not taken");
  a_converter_on: assert property (wr_conv && cfg_wdata_in[aecb_pkg::BIT_CONV_EN]
    |=> converter_on_out && reference_on_out && bias_current_on_out)
    else $error("converter not on after enable set");
  a_read_conv: assert property (cfg_rd_in && cfg_addr_in == aecb_pkg::ADDR_CONV
    |=> cfg_rvalid_out && cfg_rdata_out[aecb_pkg::BIT_CONV_EN] == $past(converter_on_out))
    else $error("converter enable readback wrong");
  a_battery_off: assert property (wr_batt && !cfg_wdata_in[aecb_pkg::BIT_BATT]
    |=> !battery_load_on_out && !battery_to_converter_out)
    else $error("battery load kept after clear");
  a_boot_end_hold: assert property (!wr_boot && !wake_in |=> $stable(boot_region_end_out))
    else $error("boot region end moved without write");
  a_clock_hold: assert property (!wr_engine && !wake_in |=> $stable(engine_clock_fast_out))
    else $error("engine clock select moved without write");
  a_base_frozen: assert property (engine_run_out && !wake_in
    && !(wr_engine && !cfg_wdata_in[aecb_pkg::BIT_RUN_EN]) |=> $stable(engine_program_base_out))
    else $error("program base moved while engine running");
  a_swap_master_off: assert property (wr_swap_en && !cfg_wdata_in[aecb_pkg::BIT_SWAP_EN]
    |=> current_swap_out == 4'h0)
    else $error("channel swap kept after master cleared");
  a_reset_values: assert property ($fell(srst_in) |-> !engine_run_out && !converter_on_out
    && !battery_load_on_out && !engine_clock_fast_out && current_swap_out == 4'h0
    && boot_region_end_out == aecb_pkg::region_base(aecb_pkg::RST_BOOT_SIZE)
    && engine_program_base_out == aecb_pkg::region_base(aecb_pkg::RST_PROG_LOC))
    else $error("reset values not taken");
  a_wake_keeps_batt: assert property (wake_in |=> battery_load_on_out == $past(battery_load_on_out))
    else $error("wake changed battery measure");
  a_engine_idle: assert property (!engine_run_out |-> !engine_start_out)
    else $error("engine started while disabled");
  a_start_single: assert property (engine_start_out |=> !engine_start_out)
    else $error("engine start longer than one cycle");
  c_engine_started: cover property (engine_start_out);
  c_battery_on: cover property (battery_load_on_out);
  c_swap_active: cover property (current_swap_out == 4'hF);
endmodule // aecb_config_bank

//--- tb/tb_afe_engine_config_bits.sv
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, gt); end end
module tb_afe_engine_config_bits;
  logic mclk_in;
  logic srst_in;
  logic wake_in;
  logic [15:0] cfg_addr_in;
  logic cfg_wr_in;
  logic [7:0] cfg_wdata_in;
  logic cfg_rd_in;
  logic [7:0] cfg_rdata_out;
  logic cfg_rvalid_out;
  logic sync_in;
  logic acc_in;
  logic conv_on, ref_on, bias_on, batt_load, batt_conn, ref_swap, alt_req, clk_fast, run, start;
  logic [3:0] cur_swap;
  logic [aecb_pkg::REGION_AW-1:0] prog_base;
  logic [aecb_pkg::REGION_AW-1:0] boot_end;
  int error_cnt = 0;
  int total_checks = 0;

  aecb_config_bank aecb_config_bank_i (
    .mclk_in(mclk_in), .srst_in(srst_in), .wake_in(wake_in),
    .cfg_addr_in(cfg_addr_in), .cfg_wr_in(cfg_wr_in), .cfg_wdata_in(cfg_wdata_in),
    .cfg_rd_in(cfg_rd_in), .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out),
    .multiplexer_frame_sync_in(sync_in), .accumulation_interval_in(acc_in),
    .converter_on_out(conv_on), .reference_on_out(ref_on), .bias_current_on_out(bias_on),
    .battery_load_on_out(batt_load), .battery_to_converter_out(batt_conn),
    .reference_swap_out(ref_swap), .alternative_frame_request_out(alt_req),
    .current_swap_out(cur_swap), .engine_clock_fast_out(clk_fast), .engine_run_out(run),
    .engine_start_out(start), .engine_program_base_out(prog_base), .boot_region_end_out(boot_end)
  );

  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one write, returns at the falling edge after the taking edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    cfg_addr_in = a;
    cfg_wdata_in = d;
    cfg_wr_in = 1'b1;
    @(posedge mclk_in);
    @(negedge mclk_in);
    cfg_wr_in = 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] ex);
    @(negedge mclk_in);
    cfg_addr_in = a;
    cfg_rd_in = 1'b1;
    @(posedge mclk_in);
    @(negedge mclk_in);
    cfg_rd_in = 1'b0;
    `CHK("rvalid", 1'b1, cfg_rvalid_out)
    `CHK("rdata", ex, cfg_rdata_out)
    @(negedge mclk_in);
    `CHK("rvalid_end", 1'b0, cfg_rvalid_out)
  endtask

  // one sync rise, then low for a cycle
  task automatic sync_chk(input logic acc, input logic ex_swap, input logic ex_alt);
    sync_in = 1'b1;
    acc_in = acc;
    @(posedge mclk_in);
    @(negedge mclk_in);
    sync_in = 1'b0;
    acc_in = 1'b0;
    `CHK("ref_swap", ex_swap, ref_swap)
    `CHK("alt_req", ex_alt, alt_req)
    @(negedge mclk_in);
    `CHK("alt_req_end", 1'b0, alt_req)
  endtask

  task automatic t_reset();
    `CHK("boot_end_rst", 18'h00400, boot_end)
    `CHK("prog_base_rst", 18'h0C400, prog_base)
    `CHK("conv_rst", 1'b0, conv_on)
    `CHK("run_rst", 1'b0, run)
    rd_chk(16'h20A7, 8'h01);
    rd_chk(16'h20A8, 8'h31);
    rd_chk(16'h2002, 8'h00);
    rd_chk(16'h2001, 8'h00);
  endtask

  task automatic t_power();
    wr(16'h2005, 8'hFF);
    `CHK("conv_on", 1'b1, conv_on)
    `CHK("ref_on", 1'b1, ref_on)
    `CHK("bias_on", 1'b1, bias_on)
    rd_chk(16'h2005, 8'h08);
    wr(16'h2005, 8'hF7);
    `CHK("conv_off", 3'b000, {conv_on, ref_on, bias_on})
    wr(16'h2020, 8'h40);
    `CHK("batt_load", 1'b1, batt_load)
    `CHK("batt_conn", 1'b1, batt_conn)
    rd_chk(16'h2020, 8'h40);
    wr(16'h20A7, 8'hFF);
    `CHK("boot_end_ff", 18'h3FC00, boot_end)
    wr(16'h3000, 8'hFF);
    rd_chk(16'h3000, 8'h00);
  endtask

  task automatic t_engine();
    wr(16'h20A8, 8'h02);
    `CHK("base_track", 18'h00800, prog_base)
    wr(16'h2000, 8'h08);
    `CHK("clk_fast", 1'b1, clk_fast)
    `CHK("run_idle", 1'b0, run)
    `CHK("start_idle", 1'b0, start)
    wr(16'h2000, 8'h10);
    `CHK("clk_slow", 1'b0, clk_fast)
    `CHK("run_on", 1'b1, run)
    `CHK("start_on", 1'b1, start)
    `CHK("base_start", 18'h00800, prog_base)
    @(negedge mclk_in);
    `CHK("start_pulse", 1'b0, start)
    rd_chk(16'h2000, 8'h10);
    wr(16'h20A8, 8'h03);
    `CHK("base_frozen", 18'h00800, prog_base)
    wr(16'h2000, 8'h00);
    `CHK("run_off", 1'b0, run)
  endtask

  task automatic t_chop();
    wr(16'h2002, 8'h20);
    `CHK("swap_no_sync", 1'b0, ref_swap)
    sync_chk(1'b0, 1'b1, 1'b0);
    sync_chk(1'b1, 1'b1, 1'b0);
    wr(16'h2002, 8'h10);
    `CHK("swap_wait", 1'b1, ref_swap)
    sync_chk(1'b0, 1'b0, 1'b0);
    wr(16'h2002, 8'h30);
    sync_chk(1'b0, 1'b1, 1'b0);
    sync_chk(1'b1, 1'b0, 1'b0);
    wr(16'h2002, 8'h00);
    sync_chk(1'b0, 1'b1, 1'b0);
    sync_chk(1'b1, 1'b1, 1'b1);
    sync_chk(1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_swap();
    wr(16'h20AC, 8'h11);
    wr(16'h20AD, 8'h01);
    `CHK("swap_masked", 4'h0, cur_swap)
    wr(16'h20AB, 8'h01);
    `CHK("swap_abc", 4'h7, cur_swap)
    wr(16'h20AD, 8'h10);
    `CHK("swap_abd", 4'hB, cur_swap)
    rd_chk(16'h20AC, 8'h11);
    rd_chk(16'h20AD, 8'h10);
    wr(16'h20AB, 8'h00);
    `CHK("swap_off", 4'h0, cur_swap)
  endtask

  task automatic t_wake();
    wr(16'h2005, 8'h08);
    wr(16'h20A8, 8'h07);
    wr(16'h20AB, 8'h01);
    wr(16'h2002, 8'h30);
    wr(16'h2000, 8'h18);
    wake_in = 1'b1;
    @(posedge mclk_in);
    @(negedge mclk_in);
    wake_in = 1'b0;
    `CHK("wake_conv", 1'b0, conv_on)
    `CHK("wake_run", 1'b0, run)
    `CHK("wake_clk", 1'b0, clk_fast)
    `CHK("wake_batt", 1'b1, batt_load)
    `CHK("wake_boot", 18'h00400, boot_end)
    `CHK("wake_base", 18'h0C400, prog_base)
    `CHK("wake_swap", 4'h0, cur_swap)
    rd_chk(16'h2002, 8'h00);
  endtask

  // reset again in mid-run, battery bit must clear unlike on wake
  task automatic t_rerun();
    wr(16'h2000, 8'h18);
    wr(16'h2002, 8'h20);
    sync_chk(1'b0, 1'b1, 1'b0);
    srst_in = 1'b1;
    @(negedge mclk_in);
    srst_in = 1'b0;
    `CHK("rerun_run", 1'b0, run)
    `CHK("rerun_clk", 1'b0, clk_fast)
    `CHK("rerun_batt", 1'b0, batt_load)
    `CHK("rerun_swap", 1'b0, ref_swap)
    `CHK("rerun_base", 18'h0C400, prog_base)
    rd_chk(16'h2002, 8'h00);
  endtask

  initial begin
    #(40 * 3000);
    error_cnt++;
    summarize();
  end

  initial begin
    srst_in = 1'b1;
    wake_in = 1'b0;
    cfg_addr_in = 16'h0000;
    cfg_wr_in = 1'b0;
    cfg_wdata_in = 8'h00;
    cfg_rd_in = 1'b0;
    sync_in = 1'b0;
    acc_in = 1'b0;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    srst_in = 1'b0;
    @(negedge mclk_in);
    t_reset();
    t_power();
    t_engine();
    t_chop();
    t_swap();
    t_wake();
    t_rerun();
    summarize();
  end
endmodule // tb_afe_engine_config_bits
